// *** emb_mem.sv ***
/*
 * Embedded memory block: a 128 x 36 array (four 9-bit lanes, each a
 * byte plus one parity or control bit) behind two ports, configurable
 * as single-port, simple or true dual-port RAM, ROM, FIFO, tapped shift
 * register, or two independent half-size single-port memories.
 * Assumes synchronous user inputs on core_clk; mode and option inputs
 * are held static while the block is in use.
 */
// How it works
// - selectable RAM, ROM, FIFO modes, parity optional
// - inputs captured in registers before array write
// - two ports read or write independently
// - output register can be bypassed
// - simple dual-port reads may capture on falling edge
// - array preloaded with initial contents
// - two half-size single-port memories share block
// - ninth bit per byte stored, never checked
// - byte enables mask written lanes
// - shift-register mode with taps

`timescale 1ns/1ps

module emb_mem (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // configuration
    input wire emb_pkg::emb_mode_t mode,
    input wire logic parity_en,
    input wire logic out_reg_en_a,
    input wire logic out_reg_en_b,
    input wire logic pseudo_async,
    input wire logic [emb_pkg::ADDR_W-1:0] tap_len,
    // port a
    input wire logic [emb_pkg::ADDR_W-1:0] addr_a,
    input wire logic [emb_pkg::DATA_W-1:0] wdata_a,
    input wire logic [emb_pkg::LANES-1:0] wpar_a,
    input wire logic [emb_pkg::LANES-1:0] byte_en_a,
    input wire logic wr_en_a,
    input wire logic rd_en_a,
    output logic [emb_pkg::WORD_W-1:0] rdata_a,
    // port b
    input wire logic [emb_pkg::ADDR_W-1:0] addr_b,
    input wire logic [emb_pkg::DATA_W-1:0] wdata_b,
    input wire logic [emb_pkg::LANES-1:0] wpar_b,
    input wire logic [emb_pkg::LANES-1:0] byte_en_b,
    input wire logic wr_en_b,
    input wire logic rd_en_b,
    output logic [emb_pkg::WORD_W-1:0] rdata_b,
    // fifo status
    output logic fifo_full,
    output logic fifo_empty
);
    localparam int AW = emb_pkg::ADDR_W;
    localparam int LW = emb_pkg::LANE_W;
    localparam int BW = emb_pkg::BYTE_W;

    // ======================================================================
    // port slices
    // ======================================================================
    logic [AW-1:0] a_addr_q, b_addr_q;
    logic [emb_pkg::DATA_W-1:0] a_wdata_q, b_wdata_q;
    logic [emb_pkg::LANES-1:0] a_wpar_q, b_wpar_q, a_be_q, b_be_q;
    logic a_we_q, b_we_q, a_re_q, b_re_q;
    logic [emb_pkg::WORD_W-1:0] mem_q [emb_pkg::DEPTH];
    logic [AW-1:0] b_neg_addr_q;
    logic b_neg_re_q;
    logic [AW-1:0] wr_ptr_q, rd_ptr_q;
    logic [emb_pkg::CNT_W-1:0] count_q;
    logic [emb_pkg::CNT_W-1:0] count_d;
    logic full_q, empty_q;

    wire logic [emb_pkg::WORD_W-1:0] a_rd_word;
    wire logic [emb_pkg::WORD_W-1:0] b_rd_word;
    wire logic a_rd_ok;
    wire logic b_rd_ok;

    emb_port u_port_a (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .addr(addr_a),
        .wdata(wdata_a),
        .wpar(wpar_a),
        .byte_en(byte_en_a),
        .wr_en(wr_en_a),
        .rd_en(rd_en_a),
        .out_reg_en(out_reg_en_a),
        .addr_q(a_addr_q),
        .wdata_q(a_wdata_q),
        .wpar_q(a_wpar_q),
        .byte_en_q(a_be_q),
        .wr_en_q(a_we_q),
        .rd_en_q(a_re_q),
        .rd_word(a_rd_word),
        .rd_ok(a_rd_ok),
        .rdata_q(rdata_a)
    );

    // pseudo-async reads drop the output register, so force bypass
    wire logic b_bypass = pseudo_async & (mode == emb_pkg::EMB_SIMPLE_DP);
    wire logic b_out_reg = out_reg_en_b & ~b_bypass;

    emb_port u_port_b (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .addr(addr_b),
        .wdata(wdata_b),
        .wpar(wpar_b),
        .byte_en(byte_en_b),
        .wr_en(wr_en_b),
        .rd_en(rd_en_b),
        .out_reg_en(b_out_reg),
        .addr_q(b_addr_q),
        .wdata_q(b_wdata_q),
        .wpar_q(b_wpar_q),
        .byte_en_q(b_be_q),
        .wr_en_q(b_we_q),
        .rd_en_q(b_re_q),
        .rd_word(b_rd_word),
        .rd_ok(b_rd_ok),
        .rdata_q(rdata_b)
    );

    // ======================================================================
    // mode decode
    // ======================================================================
    wire logic is_fifo = (mode == emb_pkg::EMB_FIFO);
    wire logic is_shift = (mode == emb_pkg::EMB_SHIFT);
    wire logic is_rom = (mode == emb_pkg::EMB_ROM);
    wire logic is_two = (mode == emb_pkg::EMB_TWO_SINGLE);
    wire logic is_tdp = (mode == emb_pkg::EMB_TRUE_DP);
    wire logic b_writes = is_tdp | is_two;
    wire logic fifo_push = is_fifo & a_we_q & ~full_q;
    wire logic fifo_pop = is_fifo & b_re_q & ~empty_q;

    // ======================================================================
    // write path
    // ======================================================================
    // rom never writes; fifo and shift write whole words
    wire logic a_wr = is_shift | fifo_push | (a_we_q & ~is_rom & ~is_fifo);
    wire logic b_wr = b_we_q & b_writes;
    wire logic [AW-1:0] a_waddr = (is_fifo | is_shift) ? wr_ptr_q :
                                  is_two ? {1'b0, a_addr_q[AW-2:0]} : a_addr_q;
    wire logic [AW-1:0] b_waddr = is_two ? {1'b1, b_addr_q[AW-2:0]} : b_addr_q;
    wire logic [emb_pkg::LANES-1:0] a_lanes = (is_fifo | is_shift) ?
                                              emb_pkg::LANES_ALL : a_be_q;
    // ninth bit stored as given when parity is on, else zero
    wire logic [emb_pkg::LANES-1:0] a_par = parity_en ? a_wpar_q : emb_pkg::LANES_ZERO;
    wire logic [emb_pkg::LANES-1:0] b_par = parity_en ? b_wpar_q : emb_pkg::LANES_ZERO;

    // one flop word per entry, preloaded at reset; port a wins a collision
    for (genvar i = 0; i < emb_pkg::DEPTH; i++) begin : g_word
        // preload word as a constant so the reset branch loads constants only
        localparam logic [emb_pkg::WORD_W-1:0] INIT_W = emb_pkg::emb_init_word(i);
        wire logic hit_a = a_wr & (a_waddr == AW'(i));
        wire logic hit_b = b_wr & (b_waddr == AW'(i));
        for (genvar l = 0; l < emb_pkg::LANES; l++) begin : g_lane
            wire logic wa = hit_a & a_lanes[l];
            wire logic wb = hit_b & b_be_q[l];
            wire logic [LW-1:0] lane_a = {a_par[l], a_wdata_q[l*BW +: BW]};
            wire logic [LW-1:0] lane_b = {b_par[l], b_wdata_q[l*BW +: BW]};
            always_ff @(posedge core_clk or negedge reset_n) begin
                if (!reset_n) begin
                    mem_q[i][l*LW +: LW] <= INIT_W[l*LW +: LW];
                end else if (wa) begin
                    mem_q[i][l*LW +: LW] <= lane_a;
                end else if (wb) begin
                    mem_q[i][l*LW +: LW] <= lane_b;
                end
            end
        end
    end

    // ======================================================================
    // read path
    // ======================================================================
    // falling-edge capture of b's read request halves its latency
    always_ff @(negedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            b_neg_addr_q <= emb_pkg::PTR_ZERO;
            b_neg_re_q <= 1'b0;
        end else begin
            b_neg_addr_q <= addr_b;
            b_neg_re_q <= rd_en_b;
        end
    end

    // shift taps sit tap_len and twice tap_len words behind the writer
    wire logic [AW-1:0] tap1_addr = wr_ptr_q - tap_len;
    wire logic [AW-1:0] tap2_addr = wr_ptr_q - AW'({tap_len, 1'b0});
    wire logic [AW-1:0] a_raddr = is_shift ? tap1_addr :
                                  is_two ? {1'b0, a_addr_q[AW-2:0]} : a_addr_q;
    wire logic [AW-1:0] b_raddr = is_shift ? tap2_addr :
                                  is_fifo ? rd_ptr_q :
                                  b_bypass ? b_neg_addr_q :
                                  is_two ? {1'b1, b_addr_q[AW-2:0]} : b_addr_q;
    assign a_rd_word = mem_q[a_raddr];
    assign b_rd_word = mem_q[b_raddr];
    // simple dual-port: a writes only, b reads only
    assign a_rd_ok = is_shift | (a_re_q & ~is_fifo & (mode != emb_pkg::EMB_SIMPLE_DP));
    assign b_rd_ok = is_shift | fifo_pop | (b_bypass ? b_neg_re_q :
                     (b_re_q & ~is_fifo & (mode != emb_pkg::EMB_SINGLE)));

    // ======================================================================
    // fifo and shift pointers
    // ======================================================================
    // count only, flags derived from it so they never disagree
    always_comb begin
        count_d = count_q;
        if (fifo_push & ~fifo_pop) begin
            count_d = count_q + 8'h01;
        end else if (fifo_pop & ~fifo_push) begin
            count_d = count_q - 8'h01;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_q <= emb_pkg::PTR_ZERO;
            rd_ptr_q <= emb_pkg::PTR_ZERO;
            count_q <= emb_pkg::CNT_ZERO;
            full_q <= 1'b0;
            empty_q <= 1'b1;
        end else begin
            if (fifo_push | is_shift) begin
                wr_ptr_q <= wr_ptr_q + emb_pkg::PTR_ONE;
            end
            if (fifo_pop) begin
                rd_ptr_q <= rd_ptr_q + emb_pkg::PTR_ONE;
            end
            count_q <= count_d;
            full_q <= (count_d == emb_pkg::FIFO_FULL_CNT);
            empty_q <= (count_d == emb_pkg::CNT_ZERO);
        end
    end

    assign fifo_full = full_q;
    assign fifo_empty = empty_q;
endmodule

// *** emb_port.sv ***
/*
 * Shared constants for the embedded memory block, and one port slice:
 * the input registers that hold a port's request and the optional
 * pipeline register on its read data.
 * Assumes one clock (core_clk) and an active-low asynchronous reset;
 * the array itself lives in the parent and feeds back rd_word.
 */

// ==========================================================================
// package
// ==========================================================================
package emb_pkg;
    localparam int DATA_W = 32;
    localparam int LANES = 4;
    localparam int BYTE_W = 8;
    localparam int LANE_W = 9;
    localparam int WORD_W = 36;
    localparam int DEPTH = 128;
    localparam int ADDR_W = 7;
    localparam int CAPACITY = 4608;
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] FIFO_FULL_CNT = 8'h80;
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
    localparam logic [ADDR_W-1:0] PTR_ONE = 7'h01;
    localparam logic [ADDR_W-1:0] PTR_ZERO = 7'h00;
    localparam logic [WORD_W-1:0] WORD_ZERO = 36'h0_0000_0000;
    localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;
    localparam logic [LANES-1:0] LANES_ZERO = 4'h0;
    localparam logic [LANES-1:0] LANES_ALL = 4'hF;
    // preload pattern; value is arbitrary, chosen only to be non-zero
    localparam logic [WORD_W-1:0] INIT_SEED = 36'h9_A5C3_0F01;

    typedef enum logic [2:0] {
        EMB_SINGLE,
        EMB_SIMPLE_DP,
        EMB_TRUE_DP,
        EMB_ROM,
        EMB_FIFO,
        EMB_SHIFT,
        EMB_TWO_SINGLE
    } emb_mode_t;

    // preload value of one entry; constant per index
    function automatic logic [WORD_W-1:0] emb_init_word(input int idx);
        logic [WORD_W-1:0] w;
        w = INIT_SEED ^ WORD_W'(idx * 32'h0001_0101);
        return w;
    endfunction
endpackage

`timescale 1ns/1ps

// ==========================================================================
// port slice
// ==========================================================================
module emb_port (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // user request
    input wire logic [emb_pkg::ADDR_W-1:0] addr,
    input wire logic [emb_pkg::DATA_W-1:0] wdata,
    input wire logic [emb_pkg::LANES-1:0] wpar,
    input wire logic [emb_pkg::LANES-1:0] byte_en,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic out_reg_en,
    // captured request
    output logic [emb_pkg::ADDR_W-1:0] addr_q,
    output logic [emb_pkg::DATA_W-1:0] wdata_q,
    output logic [emb_pkg::LANES-1:0] wpar_q,
    output logic [emb_pkg::LANES-1:0] byte_en_q,
    output logic wr_en_q,
    output logic rd_en_q,
    // array side and read result
    input wire logic [emb_pkg::WORD_W-1:0] rd_word,
    input wire logic rd_ok,
    output logic [emb_pkg::WORD_W-1:0] rdata_q
);
    logic [emb_pkg::WORD_W-1:0] pipe_q;
    logic pipe_vld_q;
    wire logic take_bypass = ~out_reg_en & rd_ok;
    wire logic take_pipe = out_reg_en & pipe_vld_q;

    // input registers: array sees only captured values
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            addr_q <= emb_pkg::PTR_ZERO;
            wdata_q <= emb_pkg::DATA_ZERO;
            wpar_q <= emb_pkg::LANES_ZERO;
            byte_en_q <= emb_pkg::LANES_ZERO;
            wr_en_q <= 1'b0;
            rd_en_q <= 1'b0;
        end else begin
            addr_q <= addr;
            wdata_q <= wdata;
            wpar_q <= wpar;
            byte_en_q <= byte_en;
            wr_en_q <= wr_en;
            rd_en_q <= rd_en;
        end
    end

    // output stage: bypass gives data one edge after capture, pipe two
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pipe_q <= emb_pkg::WORD_ZERO;
            pipe_vld_q <= 1'b0;
            rdata_q <= emb_pkg::WORD_ZERO;
        end else begin
            pipe_vld_q <= rd_ok;
            if (rd_ok) begin
                pipe_q <= rd_word;
            end
            if (take_bypass) begin
                rdata_q <= rd_word;
            end else if (take_pipe) begin
                rdata_q <= pipe_q;
            end
        end
    end
endmodule

// *** emb_mem_props.sv ***
/* concurrent checks on the embedded memory block's ports.
   assumes one clock core_clk and async active-low reset_n; bound from the bench. */
`timescale 1ns/1ps
// ==================================================
// port checker
// ==================================================
module emb_mem_props (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // configuration
    input wire emb_pkg::emb_mode_t mode,
    input wire logic parity_en,
    input wire logic out_reg_en_a,
    // port a
    input wire logic [6:0] addr_a,
    input wire logic [31:0] wdata_a,
    input wire logic [3:0] wpar_a,
    input wire logic [3:0] byte_en_a,
    input wire logic wr_en_a,
    input wire logic rd_en_a,
    input wire logic [35:0] rdata_a,
    // port b and fifo status
    input wire logic rd_en_b,
    input wire logic [35:0] rdata_b,
    input wire logic fifo_full,
    input wire logic fifo_empty
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // lane packing, ninth bit above each byte
    function automatic logic [35:0] pk(input logic [31:0] d, input logic [3:0] p);
        return {p[3], d[31:24], p[2], d[23:16], p[1], d[15:8], p[0], d[7:0]};
    endfunction
    // ports whose read data only moves on a read
    wire ram_a = mode inside {emb_pkg::EMB_SINGLE, emb_pkg::EMB_TRUE_DP, emb_pkg::EMB_ROM,
        emb_pkg::EMB_TWO_SINGLE};
    wire ram_b = mode inside {emb_pkg::EMB_TRUE_DP, emb_pkg::EMB_TWO_SINGLE};
    wire fifo = mode == emb_pkg::EMB_FIFO;
    // full-word write then read-back of the same word
    sequence s_full_wr;
        mode == emb_pkg::EMB_SINGLE && parity_en && wr_en_a && !rd_en_a && byte_en_a == 4'hF;
    endsequence
    sequence s_same_rd;
        rd_en_a && !wr_en_a && addr_a == $past(addr_a);
    endsequence
    a_wr_rd_bypass: assert property (s_full_wr ##1 s_same_rd ##0 !out_reg_en_a
        |-> ##2 rdata_a == pk($past(wdata_a, 3), $past(wpar_a, 3)))
        else $error("bypass readback");
    a_wr_rd_reg: assert property (s_full_wr ##1 s_same_rd ##0 out_reg_en_a
        |-> ##3 rdata_a == pk($past(wdata_a, 4), $past(wpar_a, 4)))
        else $error("registered readback");
    // a registered read moves rdata three samples after its request
    a_hold_a: assert property (ram_a && !$past(rd_en_a) && !$past(rd_en_a, 2)
        && !$past(rd_en_a, 3) |-> $stable(rdata_a)) else $error("rdata_a moved without a read");
    a_hold_b: assert property (ram_b && !$past(rd_en_b) && !$past(rd_en_b, 2)
        && !$past(rd_en_b, 3) |-> $stable(rdata_b)) else $error("rdata_b moved without a read");
    a_flags_excl: assert property (!(fifo_full && fifo_empty)) else $error("full and empty");
    a_push_fill: assert property (fifo && wr_en_a |-> ##[1:2] !fifo_empty)
        else $error("push left fifo empty");
    a_full_keep: assert property (fifo && fifo_full && !rd_en_b && !$past(rd_en_b)
        |=> fifo_full) else $error("full dropped without pop");
    a_pop_empty: assert property (fifo && fifo_empty && !wr_en_a && !$past(wr_en_a)
        && !$past(rd_en_b) |=> $stable(rdata_b)) else $error("pop on empty moved data");
endmodule

// *** emb_user.sv ***
/* user-logic model driving one memory port.
   assumes the bench posts requests after a rising edge; they land at the falling edge. */
`timescale 1ns/1ps
// ==================================================
// user port model
// ==================================================
module emb_user (
    // clock
    input wire logic core_clk,
    // request lines
    output logic [6:0] addr,
    output logic [31:0] wdata,
    output logic [3:0] wpar,
    output logic [3:0] byte_en,
    output logic wr_en,
    output logic rd_en
);
    logic w_n = 1'b0;
    logic r_n = 1'b0;
    logic [6:0] a_n;
    logic [31:0] d_n;
    logic [3:0] p_n;
    logic [3:0] be_n;
    initial begin
        {addr, wdata, wpar, byte_en, wr_en, rd_en} = '0;
    end
    // post one request for the next cycle
    task automatic put(input logic w, input logic r, input logic [6:0] a,
        input logic [31:0] d, input logic [3:0] p, input logic [3:0] be);
        {w_n, r_n, a_n, d_n, p_n, be_n} = {w, r, a, d, p, be};
    endtask
    // unqualified lines toggle so a stale value can never pass for a request
    always @(negedge core_clk) begin
        wr_en <= w_n;
        rd_en <= r_n;
        addr <= (w_n | r_n) ? a_n : ~addr;
        wdata <= w_n ? d_n : ~wdata;
        wpar <= w_n ? p_n : ~wpar;
        byte_en <= w_n ? be_n : ~byte_en;
        w_n = 1'b0;
        r_n = 1'b0;
    end
endmodule

// *** emb_mem_tb.sv ***
/* self-checking bench for emb_mem: two user port models, a shadow array and a
   queue of expected read results. assumes emb_user and emb_mem_props compiled first. */
`timescale 1ns/1ps
// ==================================================
// bench top
// ==================================================
module emb_mem_tb;
    typedef struct {int cyc; bit b; logic [35:0] v;} emb_note_t;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    emb_pkg::emb_mode_t mode = emb_pkg::EMB_SINGLE;
    logic pe = 1'b1, ra = 1'b0, rb = 1'b0, pa = 1'b0;
    logic [6:0] tap = 7'h04;
    logic [6:0] addr_a, addr_b;
    logic [31:0] wdata_a, wdata_b;
    logic [3:0] wpar_a, wpar_b, byte_en_a, byte_en_b;
    logic wr_en_a, wr_en_b, rd_en_a, rd_en_b, fifo_full, fifo_empty;
    logic [35:0] rdata_a, rdata_b, mem [128];
    emb_note_t q[$];
    logic [35:0] fq[$];
    int cyc = 0, failures = 0, checks = 0, seed = 98;
    always #5 core_clk = ~core_clk;
    emb_user ua (.core_clk(core_clk), .addr(addr_a), .wdata(wdata_a), .wpar(wpar_a),
        .byte_en(byte_en_a), .wr_en(wr_en_a), .rd_en(rd_en_a));
    emb_user ub (.core_clk(core_clk), .addr(addr_b), .wdata(wdata_b), .wpar(wpar_b),
        .byte_en(byte_en_b), .wr_en(wr_en_b), .rd_en(rd_en_b));
    emb_mem dut (.core_clk(core_clk), .reset_n(reset_n), .mode(mode), .parity_en(pe),
        .out_reg_en_a(ra), .out_reg_en_b(rb), .pseudo_async(pa), .tap_len(tap),
        .addr_a(addr_a), .wdata_a(wdata_a), .wpar_a(wpar_a), .byte_en_a(byte_en_a),
        .wr_en_a(wr_en_a), .rd_en_a(rd_en_a), .rdata_a(rdata_a), .addr_b(addr_b),
        .wdata_b(wdata_b), .wpar_b(wpar_b), .byte_en_b(byte_en_b), .wr_en_b(wr_en_b),
        .rd_en_b(rd_en_b), .rdata_b(rdata_b), .fifo_full(fifo_full), .fifo_empty(fifo_empty));
    task automatic check(input string n, input logic [35:0] s, input logic [35:0] e);
        checks++;
        if (s !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic tally_and_finish;
        if (failures == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // result watcher: the oldest note is judged once its cycle has come
    always @(posedge core_clk) begin
        cyc++;
        #1;
        while (q.size() > 0 && q[0].cyc <= cyc) begin
            check(q[0].b ? "rdata_b" : "rdata_a", q[0].b ? rdata_b : rdata_a, q[0].v);
            void'(q.pop_front());
        end
    end
    // parity gating matches what the array keeps
    function automatic logic [35:0] pk(input logic [31:0] d, input logic [3:0] p);
        logic [3:0] g;
        g = pe ? p : 4'h0;
        return {g[3], d[31:24], g[2], d[23:16], g[1], d[15:8], g[0], d[7:0]};
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #2;
    endtask
    // read result lands one edge after capture, two with the output register
    task automatic note(input bit b, input logic [35:0] v);
        q.push_back('{cyc + 2 + (b ? int'(rb & ~pa) : int'(ra)), b, v});
    endtask
    task automatic op(input bit b, input bit w, input bit r, input logic [6:0] a,
        input logic [31:0] d, input logic [3:0] p, input logic [3:0] be);
        logic [6:0] ix;
        ix = (mode == emb_pkg::EMB_TWO_SINGLE) ? {b, a[5:0]} : a;
        if (b) begin
            ub.put(w, r, a, d, p, be);
        end else begin
            ua.put(w, r, a, d, p, be);
        end
        for (int l = 0; l < 4; l++) begin
            if (w && be[l] && mode != emb_pkg::EMB_ROM) begin
                mem[ix][9*l+:9] = 9'(pk(d, p) >> (9 * l));
            end
        end
        if (r) begin
            note(b, mem[ix]);
        end
    endtask
    // mode changes only under reset; the array comes back preloaded
    task automatic setup(input emb_pkg::emb_mode_t m, input logic p, input logic a,
        input logic b, input logic s);
        // the first reset is already low: hold it only the six cycles below
        if (reset_n) begin
            tick(4);
        end
        @(negedge core_clk);
        {reset_n, mode, pe, ra, rb, pa} = {1'b0, m, p, a, b, s};
        for (int i = 0; i < 128; i++) begin
            mem[i] = emb_pkg::INIT_SEED ^ 36'(i * 32'h0001_0101);
        end
        repeat (6) @(negedge core_clk);
        reset_n = 1'b1;
        tick(1);
    endtask
    // watchdog against a hung run
    initial begin
        repeat (20000) @(posedge core_clk);
        failures++;
        tally_and_finish();
    end
    initial begin
        logic [31:0] d;
        logic [3:0] p;
        for (int k = 0; k < 2; k++) begin
            setup(emb_pkg::EMB_SINGLE, 1'b1, 1'(k), 1'b0, 1'b0);
            for (int i = 0; i < 3; i++) begin
                tick(1);
                op(0, 0, 1, 7'(i * 63), 32'h0, 4'h0, 4'h0);
            end
            // every lane mask, each read back on the very next cycle
            for (int i = 0; i < 16; i++) begin
                d = $random(seed);
                p = 4'($random(seed));
                tick(1);
                op(0, 1, 0, 7'(i), d, p, 4'(i));
                tick(1);
                op(0, 0, 1, 7'(i), d, p, 4'h0);
            end
        end
        // both ports at once, parity storage off
        setup(emb_pkg::EMB_TRUE_DP, 1'b0, 1'b0, 1'b1, 1'b0);
        d = $random(seed);
        tick(1);
        op(0, 1, 0, 7'h10, d, 4'hF, 4'hF);
        op(1, 1, 0, 7'h20, ~d, 4'hF, 4'hF);
        tick(1);
        op(0, 0, 1, 7'h20, d, 4'h0, 4'h0);
        op(1, 0, 1, 7'h10, d, 4'h0, 4'h0);
        tick(1);
        op(0, 1, 0, 7'h30, d, 4'h5, 4'hF);
        op(1, 0, 1, 7'h20, d, 4'h0, 4'h0);
        // writes refused by the read-only mode; halves kept apart
        setup(emb_pkg::EMB_ROM, 1'b1, 1'b0, 1'b0, 1'b0);
        tick(1);
        op(0, 1, 0, 7'h09, d, 4'hA, 4'hF);
        tick(1);
        op(0, 0, 1, 7'h09, d, 4'h0, 4'h0);
        setup(emb_pkg::EMB_TWO_SINGLE, 1'b1, 1'b0, 1'b0, 1'b0);
        tick(1);
        op(0, 1, 0, 7'h45, d, 4'h3, 4'hF);
        op(1, 1, 0, 7'h45, ~d, 4'hC, 4'hF);
        tick(1);
        op(0, 0, 1, 7'h05, d, 4'h0, 4'h0);
        op(1, 0, 1, 7'h05, d, 4'h0, 4'h0);
        // falling-edge read capture ignores the output register
        setup(emb_pkg::EMB_SIMPLE_DP, 1'b1, 1'b0, 1'b1, 1'b1);
        tick(1);
        op(0, 1, 0, 7'h33, d, 4'h6, 4'hF);
        tick(1);
        op(1, 0, 1, 7'h33, d, 4'h0, 4'h0);
        // fill to full, one refused push, drain past empty
        setup(emb_pkg::EMB_FIFO, 1'b1, 1'b0, 1'b1, 1'b0);
        for (int i = 0; i < 129; i++) begin
            d = $random(seed);
            p = 4'($random(seed));
            tick(i == 128 ? 3 : 1);
            check("fifo_full", 36'(fifo_full), 36'(i == 128));
            op(0, 1, 0, 7'h00, d, p, 4'hF);
            if (i < 128) begin
                fq.push_back(pk(d, p));
            end
        end
        for (int i = 0; i < 129; i++) begin
            tick(1);
            ub.put(1'b0, 1'b1, 7'h00, 32'h0, 4'h0, 4'h0);
            if (fq.size() > 0) begin
                note(1, fq.pop_front());
            end
        end
        tick(3);
        check("fifo_empty", 36'(fifo_empty), 36'h1);
        // delay line: a held word reaches both taps
        setup(emb_pkg::EMB_SHIFT, 1'b1, 1'b0, 1'b0, 1'b0);
        for (int k = 0; k < 2; k++) begin
            d = $random(seed);
            repeat (20) begin
                tick(1);
                op(0, 1, 0, 7'h00, d, 4'h9, 4'hF);
            end
            tick(1);
            check("rdata_a", rdata_a, pk(d, 4'h9));
            check("rdata_b", rdata_b, pk(d, 4'h9));
        end
        tick(4);
        failures += q.size();
        tally_and_finish();
    end
endmodule
bind emb_mem emb_mem_props chk (.core_clk(core_clk), .reset_n(reset_n), .mode(mode),
    .parity_en(parity_en), .out_reg_en_a(out_reg_en_a), .addr_a(addr_a), .wdata_a(wdata_a),
    .wpar_a(wpar_a), .byte_en_a(byte_en_a), .wr_en_a(wr_en_a), .rd_en_a(rd_en_a),
    .rdata_a(rdata_a), .rd_en_b(rd_en_b), .rdata_b(rdata_b), .fifo_full(fifo_full),
    .fifo_empty(fifo_empty));
